// [src/oet_defines.svh]
/*
 * Offsets, field positions, reset values and timing counts of the
 * oscillator enable, ready and trim block.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef OET_DEFINES_SVH
`define OET_DEFINES_SVH

`define OET_CTRL_OFS 4'h0
`define OET_CFG_OFS 4'h4

`define OET_INT_EN_BIT 0
`define OET_INT_RDY_BIT 1
`define OET_RSV_BIT 2
`define OET_TRIM_LSB 3
`define OET_TRIM_MSB 7
`define OET_CAL_LSB 8
`define OET_CAL_MSB 15
`define OET_EXT_EN_BIT 16
`define OET_EXT_RDY_BIT 17
`define OET_BYP_BIT 18

`define OET_TRIM_RST 5'h10
`define OET_INT_EN_RST 1'b1
`define OET_INT_RDY_RST 1'b1
`define OET_EXT_EN_RST 1'b0
`define OET_EXT_RDY_RST 1'b0
`define OET_BYP_RST 1'b0

`define OET_OFF_CYCLES 3'h6

`define OET_RESP_OKAY 2'h0
`define OET_RESP_DECERR 2'h3

`endif

// [src/oet_pkg.sv]
/*
 * Types of the oscillator enable, ready and trim block.
 * Assumes nothing of its surroundings.
 */
package oet_pkg;
  typedef logic [7:0] oet_cal_t;
  typedef logic [4:0] oet_trim_t;
  typedef logic [8:0] oet_adj_t;
  typedef logic [2:0] oet_cnt_t;
  typedef logic [1:0] oet_resp_t;
endpackage

// [src/oet_pin_sync.sv]
/*
 * Three-stage synchroniser for one pin, with a filtered level and a
 * one-cycle rising-edge pulse.
 * Assumes the pin is asynchronous to aclk.
 */
`timescale 1ns/1ns
module oet_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic rise_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      if (s2_r == s3_r) begin
        level_r <= s2_r;
      end
      rise_r <= (s2_r == s3_r) && s2_r && !level_r;
    end
  end

  assign level = level_r;
  assign rise = rise_r;
endmodule // oet_pin_sync

// [src/oet_ready_track.sv]
/*
 * Ready flag of one oscillator: set while enabled once stable, and
 * cleared after a fixed count of oscillator edges once disabled.
 * Assumes stable and osc_edge come from synchronisers on aclk.
 */
`timescale 1ns/1ns
`include "oet_defines.svh"
module oet_ready_track import oet_pkg::*; #(
  parameter logic RDY_RST = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic stable,
  input wire logic osc_edge,
  output logic ready
);
  logic ready_r;
  oet_cnt_t cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_r <= RDY_RST;
      cnt_r <= 3'h0;
    end else if (enable) begin
      cnt_r <= 3'h0;
      if (stable) begin
        ready_r <= 1'b1; // [R2] [R9]
      end
    end else if (ready_r && osc_edge) begin
      if (cnt_r == `OET_OFF_CYCLES - 3'h1) begin
        ready_r <= 1'b0; // [R3] [R10]
        cnt_r <= 3'h0;
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  assign ready = ready_r;

  a_rdy_rise_cause: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    $rose(ready_r) |-> $past(enable) && $past(stable))
    else $error("ready rose without enable and stable");

  a_rdy_fall_count: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    $fell(ready_r) |-> $past(cnt_r) == 3'h5 && $past(osc_edge) && !$past(enable))
    else $error("ready fell before six oscillator edges");
endmodule // oet_ready_track

// [src/oet_osc_ctrl.sv]
/*
 * Oscillator enable, ready and trim logic with an AXI4-Lite slave for
 * the oscillator control word.
 * Assumes power and clock-monitor events are single-cycle pulses on
 * aclk, the calibration code is valid at reset release, and the
 * oscillator stable flags and clocks arrive asynchronously on pins.
 */
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
//
// Contract
// [R1] Bypass changed only while external oscillator off
// [R2] External ready flag, bit 17, hardware set
// [R3] External ready clears after six oscillator cycles
// [R4] External enable bit 16, read-write, resets zero
// [R5] Standby entry clears external enable
// [R6] Calibration bits 15:8 read-only, loaded at startup
// [R7] Trim bits 7:3 read-write, resets sixteen
// [R8] Calibration plus trim drives oscillator adjust
// [R9] Internal ready flag bit 1, resets one
// [R10] Internal ready clears after six oscillator cycles
// [R11] Internal enable bit 0, read-write, resets one
// [R12] Standby exit or clock failure sets internal enable; the code sets it on clock failure only while ext_is_sysclk is high
// [R13] Bypass bit 18 selects external clock source
// [R14] Reserved bit 2 reads zero
`timescale 1ns/1ns
`include "oet_defines.svh"
module oet_osc_ctrl import oet_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standby_entry,
  input wire logic standby_exit,
  input wire logic ext_clk_fail,
  input wire logic ext_is_sysclk,
  input wire logic [7:0] int_osc_calibration_in,
  input wire logic ext_osc_stable,
  input wire logic int_osc_stable,
  input wire logic external_high_speed_clock,
  input wire logic internal_rc_clock,
  output logic ext_osc_enable,
  output logic ext_osc_bypass,
  output logic ext_osc_ready,
  output logic int_osc_enable,
  output logic int_osc_ready,
  output logic [8:0] int_osc_adjust
);
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  oet_resp_t bresp_r;
  logic arready_r;
  logic rvalid_r;
  oet_resp_t rresp_r;
  logic [31:0] rdata_r;
  logic [3:0] awaddr_q_r;
  logic [31:0] wdata_q_r;
  logic [3:0] wstrb_q_r;
  logic ext_en_r;
  logic int_en_r;
  logic bypass_r;
  oet_trim_t trim_r;
  oet_cal_t cal_r;
  logic cal_loaded_r;
  oet_adj_t adj_r;
  logic wr_commit;
  logic ctrl_wr;
  logic int_hw_set;
  logic [3:0] pin_v;
  logic [3:0] lvl_v;
  logic [3:0] rise_v;
  logic [1:0] en_v;
  logic [1:0] rdy_v;
  logic [31:0] ctrl_word;

  // Write commits once address and data are both held
  assign wr_commit = !awready_r && !wready_r && !bvalid_r;
  assign ctrl_wr = wr_commit && (awaddr_q_r == `OET_CTRL_OFS);
  assign int_hw_set = standby_exit || (ext_clk_fail && ext_is_sysclk);

  // Pin order: stable flags first, oscillator clocks after
  assign pin_v = {internal_rc_clock, external_high_speed_clock, int_osc_stable, ext_osc_stable};
  assign en_v = {int_en_r, ext_en_r};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      oet_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(pin_v[gi]),
        .level(lvl_v[gi]),
        .rise(rise_v[gi])
      );
    end
    for (gi = 0; gi < 2; gi++) begin : g_rdy
      oet_ready_track #(
        .RDY_RST(gi == 1 ? `OET_INT_RDY_RST : `OET_EXT_RDY_RST)
      ) u_rdy (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(en_v[gi]),
        .stable(lvl_v[gi]),
        .osc_edge(rise_v[gi + 2]),
        .ready(rdy_v[gi])
      );
    end
  endgenerate

  assign ctrl_word = {13'h0000, bypass_r, rdy_v[0], ext_en_r, cal_r, trim_r, 1'b0, rdy_v[1], int_en_r}; // [R14]

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_q_r <= 4'h0;
      wdata_q_r <= 32'h00000000;
      wstrb_q_r <= 4'h0;
    end else begin
      if (awready_r && s_axi_awvalid) begin
        awready_r <= 1'b0;
        awaddr_q_r <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (wready_r && s_axi_wvalid) begin
        wready_r <= 1'b0;
        wdata_q_r <= s_axi_wdata;
        wstrb_q_r <= s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `OET_RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_r <= 1'b1;
      if (awaddr_q_r == `OET_CTRL_OFS || awaddr_q_r == `OET_CFG_OFS) begin
        bresp_r <= `OET_RESP_OKAY;
      end else begin
        bresp_r <= `OET_RESP_DECERR;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `OET_RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else if (arready_r && s_axi_arvalid) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      case ({s_axi_araddr[3:2], 2'h0})
        `OET_CTRL_OFS: begin
          rdata_r <= ctrl_word;
          rresp_r <= `OET_RESP_OKAY;
        end
        `OET_CFG_OFS: begin
          rdata_r <= 32'h00000000;
          rresp_r <= `OET_RESP_OKAY;
        end
        default: begin
          rdata_r <= 32'h00000000;
          rresp_r <= `OET_RESP_DECERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // External enable; standby entry overrides software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_r <= `OET_EXT_EN_RST;
    end else if (standby_entry) begin
      ext_en_r <= 1'b0; // [R5]
    end else if (ctrl_wr && wstrb_q_r[2]) begin
      ext_en_r <= wdata_q_r[`OET_EXT_EN_BIT]; // [R4]
    end
  end

  // Bypass is held while the external oscillator is on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bypass_r <= `OET_BYP_RST;
    end else if (ctrl_wr && wstrb_q_r[2] && !ext_en_r) begin
      bypass_r <= wdata_q_r[`OET_BYP_BIT]; // [R1] [R13]
    end
  end

  // Internal enable; hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_en_r <= `OET_INT_EN_RST;
    end else if (int_hw_set) begin
      int_en_r <= 1'b1; // [R12]
    end else if (ctrl_wr && wstrb_q_r[0]) begin
      int_en_r <= wdata_q_r[`OET_INT_EN_BIT]; // [R11]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_r <= `OET_TRIM_RST;
    end else if (ctrl_wr && wstrb_q_r[0]) begin
      trim_r <= wdata_q_r[`OET_TRIM_MSB:`OET_TRIM_LSB]; // [R7]
    end
  end

  // Calibration caught once after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_loaded_r <= 1'b0;
      cal_r <= 8'h00;
    end else if (!cal_loaded_r) begin
      cal_loaded_r <= 1'b1;
      cal_r <= int_osc_calibration_in; // [R6]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adj_r <= 9'h000;
    end else begin
      adj_r <= {1'b0, cal_r} + {4'h0, trim_r}; // [R8]
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign ext_osc_enable = ext_en_r;
  assign ext_osc_bypass = bypass_r;
  assign ext_osc_ready = rdy_v[0];
  assign int_osc_enable = int_en_r;
  assign int_osc_ready = rdy_v[1];
  assign int_osc_adjust = adj_r;

  a_ext_en_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    ctrl_wr && wstrb_q_r[2] && !standby_entry |=> ext_en_r == $past(wdata_q_r[16]))
    else $error("external enable did not take written value");

  a_ext_en_standby: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    standby_entry |=> !ext_en_r)
    else $error("standby entry left external enable set");

  a_int_en_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    ctrl_wr && wstrb_q_r[0] && !int_hw_set |=> int_en_r == $past(wdata_q_r[0]))
    else $error("internal enable did not take written value");

  a_int_en_wake: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    standby_exit || (ext_clk_fail && ext_is_sysclk) |=> int_en_r)
    else $error("internal enable not forced on");

  a_trim_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    ctrl_wr && wstrb_q_r[0] |=> trim_r == $past(wdata_q_r[7:3]))
    else $error("trim did not take written value");

  a_cal_held: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    cal_loaded_r && $past(cal_loaded_r) |-> $stable(cal_r))
    else $error("calibration changed after load");

  a_adjust_sum: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    cal_loaded_r ##1 1'b1 |-> adj_r == {1'b0, $past(cal_r)} + {4'h0, $past(trim_r)})
    else $error("adjust code is not calibration plus trim");

  a_bypass_locked: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    $past(ext_en_r) |-> $stable(bypass_r))
    else $error("bypass changed while external oscillator on");

  a_rsv_read_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    rvalid_r |-> rdata_r[2] == 1'b0)
    else $error("reserved bit read nonzero");

  a_ext_rdy_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    $fell(rdy_v[0]) |-> !$past(ext_en_r))
    else $error("external ready fell while enabled");
endmodule // oet_osc_ctrl

// [dv/oet_osc_model.sv]
/*
 Model of the external crystal and internal RC oscillators.
 Assumes enables and ready flags come from the block's outputs.
*/
`timescale 1ns/1ns
module oet_osc_model (
  input wire logic ext_en,
  input wire logic ext_byp,
  input wire logic ext_rdy,
  input wire logic int_en,
  input wire logic int_rdy,
  output logic ext_stable,
  output logic int_stable,
  output logic ext_clk,
  output logic int_clk
);
  initial begin
    ext_stable = 1'b0;
    int_stable = 1'b1;
    ext_clk = 1'b0;
    int_clk = 1'b0;
  end
  // Clocks wind down only once the flag is gone
  always #90 ext_clk = (ext_en || ext_rdy) ? ~ext_clk : 1'b0;
  always #70 int_clk = (int_en || int_rdy) ? ~int_clk : 1'b0;
  always begin
    wait (ext_en);
    #(ext_byp ? 100 : 400);
    ext_stable = ext_en;
    wait (!ext_en);
    ext_stable = 1'b0;
  end
  always begin
    wait (!int_en);
    int_stable = 1'b0;
    wait (int_en);
    #300;
    int_stable = int_en;
  end
endmodule // oet_osc_model

// [dv/oet_osc_ctrl_bench.sv]
/*
 Self-checking bench of the oscillator control block.
 Assumes the oscillator model in dv/ and a 50 MHz aclk.
*/
`timescale 1ns/1ns
module oet_osc_ctrl_bench;
  import oet_pkg::*;
  localparam logic [7:0] CAL = 8'hA5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic standby_entry = 1'b0;
  logic standby_exit = 1'b0;
  logic ext_clk_fail = 1'b0;
  logic ext_is_sysclk = 1'b0;
  logic ext_st, int_st, ext_clk, int_clk;
  logic ext_en, ext_byp, ext_rdy, int_en, int_rdy;
  logic [8:0] adj;
  int n_errors = 0;
  int cmp_count = 0;
  int n_ext = 0;
  int n_int = 0;
  always #10 aclk = ~aclk;
  always @(posedge ext_clk) n_ext++;
  always @(posedge int_clk) n_int++;
  oet_osc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .standby_entry(standby_entry),
    .standby_exit(standby_exit), .ext_clk_fail(ext_clk_fail), .ext_is_sysclk(ext_is_sysclk),
    .int_osc_calibration_in(CAL), .ext_osc_stable(ext_st), .int_osc_stable(int_st),
    .external_high_speed_clock(ext_clk), .internal_rc_clock(int_clk), .ext_osc_enable(ext_en),
    .ext_osc_bypass(ext_byp), .ext_osc_ready(ext_rdy), .int_osc_enable(int_en),
    .int_osc_ready(int_rdy), .int_osc_adjust(adj));
  oet_osc_model osc (.ext_en(ext_en), .ext_byp(ext_byp), .ext_rdy(ext_rdy), .int_en(int_en),
    .int_rdy(int_rdy), .ext_stable(ext_st), .int_stable(int_st), .ext_clk(ext_clk), .int_clk(int_clk));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er, "bresp");
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed, "rdata");
    chk(rresp, er, "rresp");
  endtask

  // One-cycle event: 0 standby entry, 1 standby exit, else clock failure
  task automatic pulse(input int which);
    @(posedge aclk);
    case (which)
      0: standby_entry <= 1'b1;
      1: standby_exit <= 1'b1;
      default: ext_clk_fail <= 1'b1;
    endcase
    @(posedge aclk);
    standby_entry <= 1'b0;
    standby_exit <= 1'b0;
    ext_clk_fail <= 1'b0;
    @(negedge aclk);
  endtask

  // Pin edges from the disable until the flag drops
  task automatic count_fall(input bit ext, output int n);
    int b;
    b = ext ? n_ext : n_int;
    for (int i = 0; i < 300 && (ext ? ext_rdy : int_rdy) !== 1'b0; i++) @(posedge aclk);
    chk(ext ? ext_rdy : int_rdy, 1'b0, "ready fall");
    n = (ext ? n_ext : n_int) - b;
  endtask

  task automatic t_reset;
    rd(4'h0, {16'h0, CAL, 8'h83}, 2'h0);
    chk(adj, CAL + 9'h10, "adjust");
    $display("reset test done");
  endtask

  task automatic t_trim;
    wr(4'h0, 32'h0000FFFD, 4'h3, 2'h0);
    rd(4'h0, {16'h0, CAL, 8'hFB}, 2'h0);
    chk(adj, CAL + 9'h1F, "adjust");
    wr(4'h0, 32'h00000081, 4'h1, 2'h0);
    $display("trim test done");
  endtask

  task automatic t_ext;
    int n;
    wr(4'h0, 32'h00040000, 4'h4, 2'h0);
    chk(ext_byp, 1'b1, "bypass");
    wr(4'h0, 32'h00050000, 4'h4, 2'h0);
    for (int i = 0; i < 200 && ext_rdy !== 1'b1; i++) @(posedge aclk);
    chk(ext_rdy, 1'b1, "ext ready rise");
    rd(4'h0, {16'h7, CAL, 8'h83}, 2'h0);
    wr(4'h0, 32'h00040000, 4'h4, 2'h0);
    count_fall(1'b1, n);
    chk(n >= 5 && n <= 6, 1'b1, "ext edges");
    wr(4'h0, 32'h00050000, 4'h4, 2'h0);
    pulse(0);
    chk(ext_en, 1'b0, "standby clear");
    $display("external test done");
  endtask

  task automatic t_int;
    int n;
    wr(4'h0, 32'h00000080, 4'h1, 2'h0);
    count_fall(1'b0, n);
    chk(n >= 5 && n <= 6, 1'b1, "int edges");
    pulse(1);
    chk(int_en, 1'b1, "standby exit");
    wr(4'h0, 32'h00000080, 4'h1, 2'h0);
    pulse(2);
    chk(int_en, 1'b0, "fail not sysclk");
    @(posedge aclk);
    ext_is_sysclk <= 1'b1;
    pulse(2);
    chk(int_en, 1'b1, "fail sysclk");
    for (int i = 0; i < 200 && int_rdy !== 1'b1; i++) @(posedge aclk);
    chk(int_rdy, 1'b1, "int ready rise");
    rd(4'h0, {16'h4, CAL, 8'h83}, 2'h0);
    $display("internal test done");
  endtask

  task automatic t_map;
    wr(4'h4, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(4'h4, 32'h0, 2'h0);
    rd(4'h0, {16'h4, CAL, 8'h83}, 2'h0);
    rd(4'h8, 32'h0, 2'h3);
    wr(4'hC, 32'hFFFFFFFF, 4'hF, 2'h3);
    $display("map test done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_trim();
    t_ext();
    t_int();
    t_map();
    print_verdict();
  end

  initial begin
    #1000000;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // oet_osc_ctrl_bench
